// File: rtl/brg_consts.svh
`ifndef BRG_CONSTS_SVH
`define BRG_CONSTS_SVH

// Register byte offsets
`define OFS_MODE          12'h000
`define OFS_DIVIDER       12'h004
`define OFS_STATUS        12'h008

// Port mode register fields
`define MODE_CLKSEL_LSB   0
`define MODE_SYNC_BIT     2
`define MODE_OVER_BIT     3
`define MODE_CHARLEN_LSB  4
`define MODE_NINE_BIT     6
`define MODE_MSB_LEAD_BIT 7
`define MODE_PARITY_LSB   8
`define MODE_STOP_LSB     11
`define MODE_TEST_LSB     13
`define MODE_WMASK        32'h00007fff
`define MODE_RESET        32'h00000000

// Rate divider register fields
`define DIV_DIVISOR_LSB   0
`define DIV_FRAC_LSB      16
`define DIV_WMASK         32'h0007ffff
`define DIV_RESET         32'h00000000

// Fixed prescale of the master clock
`define MASTER_PRESCALE   8
// External clock needs a period of at least 4.5 master clocks
`define EXT_RATIO_X10     45

`endif

// File: rtl/brg_pkg.sv
package brg_pkg;

  typedef enum logic [1:0] {
    SRC_MASTER     = 2'h0,
    SRC_MASTER_DIV = 2'h1,
    SRC_RSVD       = 2'h2,
    SRC_EXT        = 2'h3
  } clk_src_t;

  typedef enum logic [1:0] {
    TEST_NORMAL = 2'h0,
    TEST_ECHO   = 2'h1,
    TEST_LOCAL  = 2'h2,
    TEST_REMOTE = 2'h3
  } test_mode_t;

  typedef enum logic [1:0] {
    STOP_ONE      = 2'h0,
    STOP_ONE_HALF = 2'h1,
    STOP_TWO      = 2'h2,
    STOP_RSVD     = 2'h3
  } stop_bits_t;

endpackage : brg_pkg

// File: rtl/brg_ext_sync.sv
`timescale 1ns/10ps
`default_nettype none

module brg_ext_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ext_clk,
  output logic      rise
);

  logic meta;
  logic stable;
  logic last;
  logic next_meta;
  logic next_stable;
  logic next_last;

  always_comb begin
    next_meta   = ext_clk;
    next_stable = meta;
    next_last   = stable;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      last   <= 1'b0;
    end else begin
      meta   <= next_meta;
      stable <= next_stable;
      last   <= next_last;
    end
  end

  assign rise = stable & ~last;

endmodule : brg_ext_sync

`default_nettype wire

// File: rtl/brg_divider.sv
`timescale 1ns/10ps
`default_nettype none

// Modulus counter that emits a one-cycle tick every n input ticks.
module brg_divider #(
  parameter int W = 16
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] n,
  output logic              tick_out
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  always_comb begin
    next_count = count;
    tick_out   = 1'b0;
    if (n == '0) begin
      next_count = '0;
    end else if (tick_in) begin
      if (count + W'(1) >= n) begin
        next_count = '0;
        tick_out   = 1'b1;
      end else begin
        next_count = count + W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule : brg_divider

`default_nettype wire

// File: rtl/brg_top.sv
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "brg_consts.svh"

module brg_top #(
  parameter int DIVISOR_W  = 16,
  parameter int FRACTION_W = 3,
  parameter int PRESCALE   = `MASTER_PRESCALE
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        port_clk_en,
  input  wire logic        ext_clk,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             sample_tick,
  output logic             baud_tick,
  output logic [3:0]       data_bits,
  output logic             msb_first,
  output logic [2:0]       parity_mode,
  output logic [1:0]       stop_bits,
  output logic [1:0]       test_mode
);

  // ****************************************************************
  // Register file
  // ****************************************************************

  logic [31:0] mode_reg;
  logic [31:0] div_reg;
  logic        aw_held;
  logic        w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [31:0] next_mode_reg;
  logic [31:0] next_div_reg;
  logic        next_aw_held;
  logic        next_w_held;
  logic [11:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_awready;
  logic        next_wready;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_arready;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        do_write;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st,
                                        input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r & msk;
  endfunction : merge

  function automatic logic decoded(input logic [11:0] a);
    return a == `OFS_MODE || a == `OFS_DIVIDER || a == `OFS_STATUS;
  endfunction : decoded

  logic [31:0] status_word;

  always_comb begin
    next_mode_reg = mode_reg;
    next_div_reg  = div_reg;
    next_aw_held  = aw_held;
    next_w_held   = w_held;
    next_aw_addr  = aw_addr;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_bvalid   = s_axi_bvalid;
    next_bresp    = s_axi_bresp;
    next_rvalid   = s_axi_rvalid;
    next_rdata    = s_axi_rdata;
    next_rresp    = s_axi_rresp;
    do_write      = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) next_bvalid = 1'b0;
    if (aw_held && w_held && !s_axi_bvalid) begin
      do_write     = 1'b1;
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = decoded(aw_addr) ? 2'h0 : 2'h2;
      if (aw_addr == `OFS_MODE)
        next_mode_reg = merge(mode_reg, w_data, w_strb, `MODE_WMASK);
      if (aw_addr == `OFS_DIVIDER)
        next_div_reg = merge(div_reg, w_data, w_strb, `DIV_WMASK);
    end
    if (s_axi_rvalid && s_axi_rready) next_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = decoded(s_axi_araddr) ? 2'h0 : 2'h2;
      case (s_axi_araddr)
        `OFS_MODE:    next_rdata = mode_reg;
        `OFS_DIVIDER: next_rdata = div_reg;
        `OFS_STATUS:  next_rdata = status_word;
        default:      next_rdata = 32'h00000000;
      endcase
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg      <= `MODE_RESET;
      div_reg       <= `DIV_RESET;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end else begin
      mode_reg      <= next_mode_reg;
      div_reg       <= next_div_reg;
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      aw_addr       <= next_aw_addr;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // ****************************************************************
  // Field decode
  // ****************************************************************

  brg_pkg::clk_src_t     src_sel;
  logic                  sync_mode;
  logic                  over;
  logic [DIVISOR_W-1:0]  divisor;
  logic [FRACTION_W-1:0] fraction;

  assign src_sel   = brg_pkg::clk_src_t'(mode_reg[`MODE_CLKSEL_LSB +: 2]);
  assign sync_mode = mode_reg[`MODE_SYNC_BIT];
  assign over      = mode_reg[`MODE_OVER_BIT];
  assign divisor   = div_reg[`DIV_DIVISOR_LSB +: DIVISOR_W];
  assign fraction  = div_reg[`DIV_FRAC_LSB +: FRACTION_W];

  // ****************************************************************
  // Source selection
  // ****************************************************************

  logic       ext_rise;
  logic       pre_tick;
  logic [7:0] pre_count;
  logic [7:0] next_pre_count;
  logic       src_tick;
  logic       run;

  assign run = port_clk_en;

  brg_ext_sync u_ext (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ext_clk (ext_clk),
    .rise    (ext_rise)
  );

  always_comb begin
    next_pre_count = pre_count;
    pre_tick       = 1'b0;
    if (run) begin
      if (pre_count == 8'(PRESCALE - 1)) begin
        next_pre_count = 8'h00;
        pre_tick       = 1'b1;
      end else begin
        next_pre_count = pre_count + 8'h01;
      end
    end
  end

  always_comb begin
    case (src_sel)
      brg_pkg::SRC_MASTER:     src_tick = run;
      brg_pkg::SRC_MASTER_DIV: src_tick = pre_tick;
      brg_pkg::SRC_EXT:        src_tick = run & ext_rise;
      default:                 src_tick = 1'b0;
    endcase
  end

  // ****************************************************************
  // Divider chain
  // ****************************************************************

  // Fraction: outside sync mode, every eighth-step adds one source tick over eight periods.
  logic [2:0]           frac_acc;
  logic [2:0]           next_frac_acc;
  logic [3:0]           frac_sum;
  logic                 frac_extra;
  logic                 stretch;
  logic                 next_stretch;
  logic                 divided_tick;
  logic [DIVISOR_W-1:0] divisor_eff;
  logic                 div_in;

  assign frac_sum = {1'b0, frac_acc} + {1'b0, fraction};

  assign frac_extra = !sync_mode && fraction != '0 && frac_sum[3];

  assign divisor_eff = divisor;
  assign div_in      = src_tick & !stretch;

  brg_divider #(.W(DIVISOR_W)) u_divisor (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .tick_in  (div_in),
    .n        (divisor_eff),
    .tick_out (divided_tick)
  );

  always_comb begin
    next_frac_acc = frac_acc;
    next_stretch  = stretch;
    if (stretch && src_tick) next_stretch = 1'b0;
    if (divided_tick) begin
      next_frac_acc = frac_sum[2:0];
      next_stretch  = frac_extra;
    end
  end

  logic [3:0] os_count;
  logic [3:0] next_os_count;
  logic [3:0] os_last;
  logic       next_sample;
  logic       next_baud;

  assign os_last = over ? 4'h7 : 4'hf;

  always_comb begin
    next_os_count = os_count;
    next_sample   = 1'b0;
    next_baud     = 1'b0;
    if (sync_mode) begin
      next_baud     = divided_tick;
      next_sample   = divided_tick;
      next_os_count = 4'h0;
    end else if (divided_tick) begin
      next_sample = 1'b1;
      if (os_count >= os_last) begin
        next_os_count = 4'h0;
        next_baud     = 1'b1;
      end else begin
        next_os_count = os_count + 4'h1;
      end
    end
  end

  // ****************************************************************
  // Character format outputs
  // ****************************************************************

  logic [3:0] next_data_bits;
  logic [1:0] next_stop_bits;

  always_comb begin
    next_data_bits = mode_reg[`MODE_NINE_BIT] ? 4'h9
                   : 4'h5 + {2'h0, mode_reg[`MODE_CHARLEN_LSB +: 2]};
    next_stop_bits = mode_reg[`MODE_STOP_LSB +: 2];
    if (sync_mode && next_stop_bits == brg_pkg::STOP_ONE_HALF)
      next_stop_bits = brg_pkg::STOP_ONE;
  end

  // no modem pins, no modem controls exist
  assign status_word = {24'h0, os_count, 1'b0, frac_acc};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_count   <= 8'h00;
      frac_acc    <= 3'h0;
      stretch     <= 1'b0;
      os_count    <= 4'h0;
      sample_tick <= 1'b0;
      baud_tick   <= 1'b0;
      data_bits   <= 4'h5;
      msb_first   <= 1'b0;
      parity_mode <= 3'h0;
      stop_bits   <= 2'h0;
      test_mode   <= 2'h0;
    end else begin
      pre_count   <= next_pre_count;
      frac_acc    <= next_frac_acc;
      stretch     <= next_stretch;
      os_count    <= next_os_count;
      sample_tick <= next_sample;
      baud_tick   <= next_baud;
      data_bits   <= next_data_bits;
      msb_first   <= mode_reg[`MODE_MSB_LEAD_BIT];
      parity_mode <= mode_reg[`MODE_PARITY_LSB +: 3];
      stop_bits   <= next_stop_bits;
      test_mode   <= mode_reg[`MODE_TEST_LSB +: 2];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  chk_zero_silent: assert property (
    @(posedge aclk) disable iff (!aresetn) (divisor == '0) [*2]
    |-> !sample_tick) else $error("tick with zero divisor");

  chk_bypass_pass: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (divisor == DIVISOR_W'(1) && src_sel == brg_pkg::SRC_MASTER && run
     && fraction == '0 && !stretch) |=> sample_tick)
    else $error("divisor one not bypassed");

  chk_gate_freeze: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !run |=> $stable(pre_count)) else $error("state moved while gated");

  chk_sync_stop: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sync_mode |=> stop_bits != brg_pkg::STOP_ONE_HALF)
    else $error("1.5 stop in sync");

  chk_baud_os: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (baud_tick && !sync_mode) |-> sample_tick)
    else $error("baud without sample");

  // A switch to 8x may leave a high count until the next divided tick
  chk_over_wrap: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (over && !sync_mode && divided_tick) |=> os_count <= 4'h7)
    else $error("over8 count too high");

  chk_sync_rate: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sync_mode && $past(sync_mode) |-> sample_tick == baud_tick)
    else $error("sync oversampled");

  chk_ext_edge: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ext_rise |=> !ext_rise) else $error("edge pulse too long");

endmodule : brg_top

`default_nettype wire

// File: verif/remote_clock_model.sv
`timescale 1ns/10ps
`default_nettype none

// ************************************************
// Remote serial device driving the external clock
// ************************************************
module remote_clock_model #(
  parameter int HALF_NS   = 25,
  parameter int OFFSET_NS = 2
) (
  input  wire logic run,
  output logic      ext_clk
);
  // Clock stands low between bursts; it never runs free
  initial begin
    ext_clk = 1'b0;
    forever begin
      wait (run === 1'b1);
      #OFFSET_NS;
      while (run === 1'b1) begin
        #HALF_NS ext_clk = 1'b1;
        #HALF_NS ext_clk = 1'b0;
      end
    end
  end
endmodule : remote_clock_model

`default_nettype wire

// File: verif/usart_baud_rate_generator_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module usart_baud_rate_generator_tb_top;
  typedef struct {
    logic [31:0] mode;
    logic [31:0] div;
    int          sp;
    int          bp;
    logic [11:0] fmt;
  } row_t;

  logic        aclk, aresetn, port_clk_en, ext_clk, ext_run;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, data_bits;
  logic [1:0]  s_axi_bresp, s_axi_rresp, stop_bits, test_mode;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, sample_tick, baud_tick;
  logic        msb_first;
  logic [2:0]  parity_mode;
  int          fails, comparisons;

  // Format column: data bits, msb first, parity, stop, test mode
  row_t rows [9] = '{
    '{32'h0000, 32'h00001, 1, 16, 12'h500},
    '{32'h2cb8, 32'h00003, 3, 24, 12'h8c5},
    '{32'h5111, 32'h00002, 16, 256, 12'h61a},
    '{32'h6b44, 32'h00005, 5, 5, 12'h933},
    '{32'h0228, 32'h00100, 256, 2048, 12'h720},
    '{32'h000b, 32'h00002, 10, 80, 12'h500},
    '{32'h0000, 32'h00000, 0, 0, 12'h500},
    '{32'h0002, 32'h00001, 0, 0, 12'h500},
    '{32'h0000, 32'h40002, -1, 40, 12'h500}
  };

  brg_top i_dut (
    .aclk(aclk), .aresetn(aresetn), .port_clk_en(port_clk_en),
    .ext_clk(ext_clk), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .sample_tick(sample_tick), .baud_tick(baud_tick),
    .data_bits(data_bits), .msb_first(msb_first),
    .parity_mode(parity_mode), .stop_bits(stop_bits),
    .test_mode(test_mode)
  );

  // no interrupt leaves the block; nothing edge-triggered here
  remote_clock_model i_remote (.run(ext_run), .ext_clk(ext_clk));

  // ****************
  // Shared tasks
  // ****************
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid === 1'b1 || s_axi_wvalid === 1'b1);
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic wait_tick(input bit baud, output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while ((baud ? baud_tick : sample_tick) !== 1'b1 && n < 9000);
  endtask : wait_tick

  // First two intervals after a change are discarded; the third one is exact
  task automatic measure(input bit baud, output int p);
    repeat (2) wait_tick(baud, p);
    wait_tick(baud, p);
  endtask : measure

  // ****************
  // Stimulus
  // ****************
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial begin : watchdog
    #500000;
    fails++;
    conclude();
  end

  initial begin : main
    logic [31:0] rd;
    logic [1:0]  rs;
    int          p, q;
    {aresetn, ext_run, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb} = '0;
    port_clk_en = 1'b1;
    repeat (6) @(posedge aclk);
    check("reset ticks", 32'h0, {28'h0, sample_tick, baud_tick,
          s_axi_bvalid, s_axi_rvalid});
    check("reset format", 32'h500, {20'h0, data_bits, msb_first,
          parity_mode, stop_bits, test_mode});
    aresetn <= 1'b1;
    for (int a = 0; a < 12; a += 4) begin
      axi_read(12'(a), rd, rs);
      check("reset reg", 32'h0, rd);
      check("reset resp", 32'h0, {30'h0, rs});
    end
    foreach (rows[i]) begin
      ext_run <= (rows[i].mode[1:0] == 2'h3);
      axi_write(12'h000, rows[i].mode, 4'hf, rs);
      axi_write(12'h004, rows[i].div, 4'hf, rs);
      check("write resp", 32'h0, {30'h0, rs});
      axi_read(12'h000, rd, rs);
      check("mode read", rows[i].mode, rd);
      check("format", {20'h0, rows[i].fmt}, {20'h0, data_bits, msb_first,
            parity_mode, stop_bits, test_mode});
      if (rows[i].sp == 0) begin
        q = 0;
        repeat (400) begin
          @(posedge aclk);
          if (sample_tick !== 1'b0 || baud_tick !== 1'b0) q++;
        end
        check("idle ticks", 32'h0, q);
      end else begin
        if (rows[i].sp > 0) begin
          measure(1'b0, p);
          check("sample period", rows[i].sp, p);
        end
        measure(1'b1, p);
        check("baud period", rows[i].bp, p);
      end
    end
    ext_run <= 1'b0;
    axi_write(12'h00c, 32'h1, 4'hf, rs);
    check("unmapped wresp", 32'h2, {30'h0, rs});
    axi_read(12'h010, rd, rs);
    check("unmapped rresp", 32'h2, {30'h0, rs});
    check("unmapped rdata", 32'h0, rd);
    axi_write(12'h000, 32'h0, 4'hf, rs);
    axi_write(12'h000, 32'hffffffff, 4'h1, rs);
    axi_read(12'h000, rd, rs);
    check("strobe lane", 32'h000000ff, rd);
    axi_write(12'h000, 32'hffffffff, 4'hf, rs);
    axi_read(12'h000, rd, rs);
    check("mode mask", 32'h00007fff, rd);
    axi_write(12'h000, 32'h0, 4'hf, rs);
    axi_write(12'h004, 32'hffffffff, 4'hf, rs);
    axi_read(12'h004, rd, rs);
    check("divider width", 32'h0007ffff, rd);
    axi_write(12'h004, 32'h4, 4'hf, rs);
    measure(1'b0, p);
    port_clk_en <= 1'b0;
    q = 0;
    repeat (20) begin
      @(posedge aclk);
      if (sample_tick !== 1'b0) q++;
    end
    port_clk_en <= 1'b1;
    check("frozen ticks", 32'h0, q);
    wait_tick(1'b0, p);
    check("resume gap", 32'h4, p);
    port_clk_en <= 1'b0;
    axi_write(12'h004, 32'h6, 4'hf, rs);
    axi_read(12'h004, rd, rs);
    check("gated write", 32'h6, rd);
    port_clk_en <= 1'b1;
    measure(1'b0, p);
    check("gated period", 32'h6, p);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    check("reset again", 32'h0, {28'h0, sample_tick, baud_tick,
          s_axi_bvalid, s_axi_rvalid});
    aresetn <= 1'b1;
    axi_read(12'h004, rd, rs);
    check("second reset", 32'h0, rd);
    conclude();
  end
endmodule : usart_baud_rate_generator_tb_top

`default_nettype wire
